// File: hw/bra_agu.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module bra_agu (
   input  wire logic        core_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [15:0] reg_rdata,
   // effective address request from the decoder
   input  wire logic        ea_valid,
   input  wire logic        ea_is_write,
   input  wire logic        ea_is_byte,
   input  wire logic [3:0]  ea_reg_num,
   input  wire logic [2:0]  ea_mode,
   input  wire logic [15:0] ea_pointer,
   input  wire logic [15:0] ea_offset,
   // table and instruction context
   input  wire logic        table_op,
   input  wire logic        table_high,
   input  wire logic        byte_select,
   input  wire logic        instr_move,
   input  wire logic        in_repeat,
   input  wire logic        repeat_edge,
   input  wire logic        pc_advance,
   input  wire logic [23:0] prog_rdata,
   // results
   output logic      [15:0] data_addr,
   output logic      [15:0] pointer_next,
   output logic             rev_active,
   output logic      [23:0] prog_addr,
   output logic             prog_config,
   output logic             prog_req,
   output logic      [15:0] table_rdata,
   output logic      [1:0]  extra_cycles,
   output logic      [23:0] pc
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]  table_page;
   logic [7:0]  visibility_page;
   logic [15:0] bit_reverse_control;
   logic [15:0] circular_bitrev_control;
   logic [15:0] core_control;

   function automatic logic [14:0] rev15(input logic [14:0] v);
      logic [14:0] r;
      r = '0;
      for (int i = 0; i < 15; i++) begin
         r[i] = v[14-i];
      end
      return r;
   endfunction

   wire wr_table = reg_write && (reg_addr == bra_pkg::ADDR_TABLE_PAGE);
   wire wr_vis   = reg_write && (reg_addr == bra_pkg::ADDR_VISIBILITY_PAGE);
   wire wr_rev   = reg_write && (reg_addr == bra_pkg::ADDR_BIT_REV_CTRL);
   wire wr_circ  = reg_write && (reg_addr == bra_pkg::ADDR_CIRC_CTRL);
   wire wr_core  = reg_write && (reg_addr == bra_pkg::ADDR_CORE_CTRL);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         table_page              <= bra_pkg::RST_PAGE;
         visibility_page         <= bra_pkg::RST_PAGE;
         bit_reverse_control     <= bra_pkg::RST_BIT_REV_CTRL;
         circular_bitrev_control <= bra_pkg::RST_CIRC_CTRL;
         core_control            <= bra_pkg::RST_CORE_CTRL;
      end else begin
         if (wr_table) table_page <= reg_wdata[7:0];
         if (wr_vis) visibility_page <= reg_wdata[7:0];
         if (wr_rev) bit_reverse_control <= reg_wdata;
         if (wr_circ) circular_bitrev_control <= reg_wdata;
         if (wr_core) core_control <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // bit-reversed / modulo / normal effective address
   // ------------------------------------------------------------
   wire [3:0]  rev_ptr_sel  = circular_bitrev_control[11:8];
   wire [3:0]  mod_ptr_sel  = circular_bitrev_control[3:0];
   wire        rev_en       = bit_reverse_control[bra_pkg::REV_ENABLE_BIT];
   wire [14:0] pivot        = bit_reverse_control[14:0];
   wire        mode_inc     = (ea_mode == bra_pkg::BRA_AM_PRE_INC) ||
                              (ea_mode == bra_pkg::BRA_AM_POST_INC);
   wire        mode_pre     = (ea_mode == bra_pkg::BRA_AM_PRE_INC) ||
                              (ea_mode == bra_pkg::BRA_AM_PRE_DEC);
   // stack pointer select 15 cannot be reversed
   wire        rev_cfg      = (rev_ptr_sel != bra_pkg::PTR_NONE) && rev_en;
   wire        rev_now      = ea_valid && ea_is_write && rev_cfg && mode_inc &&
                              !ea_is_byte && (ea_reg_num == rev_ptr_sel);
   // pointer and pivot are both mirrored: add in reversed bit order, mirror back
   wire [14:0] ptr_word     = ea_pointer[15:1];
   wire [14:0] rev_sum      = rev15(15'(rev15(ptr_word) + rev15(pivot)));
   wire [15:0] rev_addr     = {rev_sum, 1'b0};
   wire [15:0] mod_step     = mode_inc ? ea_offset : 16'(-ea_offset);
   wire [15:0] norm_next    = ea_pointer + mod_step;
   // modulo wrap itself lives elsewhere; here it only holds the pointer, and is gated off while a reversal is active
   wire        mod_write_on = circular_bitrev_control[bra_pkg::MOD_ENABLE_BIT] &&
                              (mod_ptr_sel != bra_pkg::PTR_NONE) && !rev_now;
   wire        ptr_mod      = (ea_mode == bra_pkg::BRA_AM_PRE_INC) ||
                              (ea_mode == bra_pkg::BRA_AM_PRE_DEC) ||
                              (ea_mode == bra_pkg::BRA_AM_POST_INC) ||
                              (ea_mode == bra_pkg::BRA_AM_POST_DEC);
   wire [15:0] next_ptr     = rev_now ? rev_addr :
                              (ptr_mod ? norm_next : ea_pointer);
   wire [15:0] next_ea      = rev_now ? (mode_pre ? rev_addr : {ea_pointer[15:1], 1'b0}) :
                              (mode_pre ? norm_next : ea_pointer);

   // ------------------------------------------------------------
   // program space address
   // ------------------------------------------------------------
   wire        vis_en      = core_control[bra_pkg::VIS_ENABLE_BIT];
   wire        vis_hit     = ea_valid && !table_op && vis_en && next_ea[15];
   wire [23:0] table_addr  = {table_page, next_ea};
   wire [23:0] vis_addr    = {1'b0, visibility_page, next_ea[14:0]};
   wire [23:0] next_paddr  = table_op ? table_addr : vis_addr;
   wire        next_cfg    = table_op && table_page[bra_pkg::TABLE_CFG_BIT];
   wire        next_preq   = ea_valid && (table_op || vis_hit);

   // ------------------------------------------------------------
   // table read data steering
   // ------------------------------------------------------------
   wire [7:0]  low_byte    = byte_select ? prog_rdata[15:8] : prog_rdata[7:0];
   wire [15:0] rd_low      = ea_is_byte ? {8'h00, low_byte} : prog_rdata[15:0];
   wire [7:0]  hi_byte     = (ea_is_byte && byte_select) ? 8'h00 : prog_rdata[23:16];
   wire [15:0] rd_high     = {8'h00, hi_byte};
   wire [15:0] next_trd    = table_high ? rd_high : rd_low;

   // ------------------------------------------------------------
   // window stall cost
   // ------------------------------------------------------------
   wire [1:0]  cost_plain  = instr_move ? bra_pkg::STALL_MOVE : bra_pkg::STALL_OTHER;
   wire [1:0]  cost_rep    = repeat_edge ? bra_pkg::STALL_REPEAT_EDGE :
                             bra_pkg::STALL_REPEAT_MID;
   // every window read except one in the middle of a repeat loop costs at least the second program fetch
   wire [1:0]  next_extra  = !vis_hit ? 2'h0 : (in_repeat ? cost_rep : cost_plain);

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   wire [15:0] status_word = {13'h0000, vis_en, rev_cfg, rev_active};
   logic [15:0] next_rdata;
   always_comb begin
      case (reg_addr)
         bra_pkg::ADDR_TABLE_PAGE:      next_rdata = {8'h00, table_page};
         bra_pkg::ADDR_VISIBILITY_PAGE: next_rdata = {8'h00, visibility_page};
         bra_pkg::ADDR_BIT_REV_CTRL:    next_rdata = bit_reverse_control;
         bra_pkg::ADDR_CIRC_CTRL:       next_rdata = circular_bitrev_control;
         bra_pkg::ADDR_CORE_CTRL:       next_rdata = core_control;
         bra_pkg::ADDR_STATUS:          next_rdata = status_word;
         default:                       next_rdata = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // output registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata    <= 16'h0000;
         data_addr    <= 16'h0000;
         pointer_next <= 16'h0000;
         rev_active   <= 1'b0;
         prog_addr    <= 24'h000000;
         prog_config  <= 1'b0;
         prog_req     <= 1'b0;
         table_rdata  <= 16'h0000;
         extra_cycles <= 2'h0;
         pc           <= bra_pkg::RST_PC;
      end else begin
         reg_rdata    <= reg_read ? next_rdata : 16'h0000;
         data_addr    <= next_ea;
         pointer_next <= mod_write_on ? ea_pointer : next_ptr;
         rev_active   <= rev_now;
         prog_addr    <= next_paddr;
         prog_config  <= next_cfg;
         prog_req     <= next_preq;
         table_rdata  <= next_trd;
         extra_cycles <= next_extra;
         if (pc_advance) pc <= pc + bra_pkg::PC_STEP;
      end
   end
endmodule

// File: hw/bra_pkg.sv
package bra_pkg;
   // ------------------------------------------------------------
   // register map (offsets chosen for this block)
   // ------------------------------------------------------------
   localparam logic [3:0]  ADDR_TABLE_PAGE      = 4'h0;
   localparam logic [3:0]  ADDR_VISIBILITY_PAGE = 4'h1;
   localparam logic [3:0]  ADDR_BIT_REV_CTRL    = 4'h2;
   localparam logic [3:0]  ADDR_CIRC_CTRL       = 4'h3;
   localparam logic [3:0]  ADDR_CORE_CTRL       = 4'h4;
   localparam logic [3:0]  ADDR_STATUS          = 4'h5;
   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int          REV_ENABLE_BIT       = 15;
   localparam int          VIS_ENABLE_BIT       = 2;
   localparam int          MOD_ENABLE_BIT       = 15;
   localparam int          TABLE_CFG_BIT        = 7;
   localparam logic [3:0]  PTR_NONE             = 4'hf;
   localparam logic [7:0]  RST_PAGE             = 8'h00;
   localparam logic [15:0] RST_BIT_REV_CTRL     = 16'h0000;
   localparam logic [15:0] RST_CIRC_CTRL        = 16'h0fff;
   localparam logic [15:0] RST_CORE_CTRL        = 16'h0000;
   localparam logic [23:0] RST_PC               = 24'h000000;
   localparam logic [23:0] PC_STEP              = 24'h000002;
   // ------------------------------------------------------------
   // addressing modes and stall costs
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      BRA_AM_DIRECT   = 3'h0,
      BRA_AM_INDIRECT = 3'h1,
      BRA_AM_POST_INC = 3'h2,
      BRA_AM_POST_DEC = 3'h3,
      BRA_AM_PRE_INC  = 3'h4,
      BRA_AM_PRE_DEC  = 3'h5,
      BRA_AM_INDEXED  = 3'h6,
      BRA_AM_LITERAL  = 3'h7
   } bra_amode_t;
   localparam logic [1:0]  STALL_MOVE           = 2'h1;
   localparam logic [1:0]  STALL_OTHER          = 2'h2;
   localparam logic [1:0]  STALL_REPEAT_EDGE    = 2'h2;
   localparam logic [1:0]  STALL_REPEAT_MID     = 2'h0;
endpackage

// File: verification/bra_agu_assertions.sv
`timescale 1ns/1ps
// ---
// port checks, one edge behind the inputs
// ---
module bra_agu_chk (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        ea_is_write,
   input wire logic        ea_is_byte,
   input wire logic [2:0]  ea_mode,
   input wire logic        table_op,
   input wire logic        instr_move,
   input wire logic        in_repeat,
   input wire logic        repeat_edge,
   input wire logic        pc_advance,
   input wire logic [15:0] data_addr,
   input wire logic        rev_active,
   input wire logic [23:0] prog_addr,
   input wire logic        prog_config,
   input wire logic        prog_req,
   input wire logic [1:0]  extra_cycles,
   input wire logic [23:0] pc
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   property p_rw; rev_active |-> $past(ea_is_write) && !$past(ea_is_byte); endproperty
   a_rw: assert property (p_rw) else $error("reversal on read or byte");
   property p_rm; rev_active |-> $past(ea_mode) inside {3'h2, 3'h4}; endproperty
   a_rm: assert property (p_rm) else $error("reversal in wrong mode");
   property p_lsb; rev_active |-> !data_addr[0]; endproperty
   a_lsb: assert property (p_lsb) else $error("reversed address odd");
   // a table op always wins the program bus, so the window can never appear under it
   property p_tab; $past(table_op) |->
      prog_addr[15:0] == data_addr && prog_config == prog_addr[23]; endproperty
   a_tab: assert property (p_tab) else $error("table address wrong");
   property p_win; prog_req && !$past(table_op) |->
      data_addr[15] && !prog_addr[23] && prog_addr[14:0] == data_addr[14:0]; endproperty
   a_win: assert property (p_win) else $error("window request wrong");
   property p_mv; prog_req && !$past(table_op) && !$past(in_repeat) |->
      extra_cycles == ($past(instr_move) ? 2'h1 : 2'h2); endproperty
   a_mv: assert property (p_mv) else $error("window cost outside loop");
   property p_rep; prog_req && !$past(table_op) && $past(in_repeat) |->
      extra_cycles == ($past(repeat_edge) ? 2'h2 : 2'h0); endproperty
   a_rep: assert property (p_rep) else $error("window cost in loop");
   property p_free; !prog_req |-> extra_cycles == 2'h0; endproperty
   a_free: assert property (p_free) else $error("cost without window");
   property p_pc; !$past(reset) |-> pc == $past(pc) + ($past(pc_advance) ? 24'h000002 : 24'h000000); endproperty
   a_pc: assert property (p_pc) else $error("counter step wrong");
endmodule
bind bra_agu bra_agu_chk u_chk (.core_clk(core_clk), .reset(reset), .ea_is_write(ea_is_write),
   .ea_is_byte(ea_is_byte), .ea_mode(ea_mode), .table_op(table_op), .instr_move(instr_move),
   .in_repeat(in_repeat), .repeat_edge(repeat_edge), .pc_advance(pc_advance),
   .data_addr(data_addr), .rev_active(rev_active), .prog_addr(prog_addr),
   .prog_config(prog_config), .prog_req(prog_req), .extra_cycles(extra_cycles), .pc(pc));

// File: verification/bra_prog_mem.sv
`timescale 1ns/1ps
// ---
// program memory: word is a fixed scramble of its address
// ---
module bra_prog_mem (
   input wire logic [23:0] prog_addr,
   input wire logic        mem_en,
   output logic     [23:0] prog_rdata
);
   // idle bus shows the inverse, so a stale word can never look right
   assign prog_rdata = mem_en ? (prog_addr ^ 24'h5ac3a5) : ~(prog_addr ^ 24'h5ac3a5);
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, a); end end
module tb_top;
   logic        core_clk = '0, reset = '1, reg_write = '0, reg_read = '0, ea_valid = '0;
   logic        ea_is_write = '0, ea_is_byte = '0, table_op = '0, table_high = '0;
   logic        byte_select = '0, instr_move = '0, in_repeat = '0, repeat_edge = '0;
   logic        pc_advance = '0, rev_active, prog_config, prog_req;
   logic [3:0]  reg_addr = '0, ea_reg_num = '0;
   logic [2:0]  ea_mode = '0;
   logic [15:0] reg_wdata = '0, ea_pointer = '0, ea_offset = 16'h0002;
   logic [15:0] reg_rdata, data_addr, pointer_next, table_rdata, p;
   logic [23:0] prog_rdata, prog_addr, pc;
   logic [1:0]  extra_cycles;
   int          fails = 0, n_tests = 0;
   bra_agu u_dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .ea_valid, .ea_is_write, .ea_is_byte, .ea_reg_num, .ea_mode, .ea_pointer, .ea_offset,
      .table_op, .table_high, .byte_select, .instr_move, .in_repeat, .repeat_edge, .pc_advance,
      .prog_rdata, .data_addr, .pointer_next, .rev_active, .prog_addr, .prog_config, .prog_req,
      .table_rdata, .extra_cycles, .pc);
   bra_prog_mem u_mem (.prog_addr, .mem_en(prog_req | table_op), .prog_rdata);
   // ---
   // bus and request tasks
   // ---
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge core_clk);
      reg_write <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge core_clk);
      reg_read <= 1'h0;
      #1 `CHK(n, e, reg_rdata)
   endtask
   task automatic ea(input logic w, b, input logic [3:0] r, input logic [2:0] m,
                     input logic [15:0] ptr);
      @(posedge core_clk);
      ea_valid <= 1'h1;
      {ea_is_write, ea_is_byte, ea_reg_num, ea_mode, ea_pointer} <= {w, b, r, m, ptr};
      @(posedge core_clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_pc_regs();
      #1 `CHK("pc rst", bra_pkg::RST_PC, pc)
      @(posedge core_clk);
      pc_advance <= 1'h1;
      repeat (3) @(posedge core_clk);
      pc_advance <= 1'h0;
      @(posedge core_clk);
      #1 `CHK("pc", 24'h000006, pc)
      rd(bra_pkg::ADDR_CIRC_CTRL, bra_pkg::RST_CIRC_CTRL, "circ rst");
      wr(bra_pkg::ADDR_TABLE_PAGE, 16'h0081);
      rd(bra_pkg::ADDR_TABLE_PAGE, 16'h0081, "page");
      wr(4'h9, 16'hffff);
      rd(4'h9, 16'h0000, "unmapped");
   endtask
   task automatic t_rev();
      logic [8:0]  neg [4] = '{9'h01a, 9'h19a, 9'h119, 9'h122};
      // pivot 8 words from 0x0100: word offsets 0, 8, 4, 12, 2, then 10
      logic [15:0] seq [4] = '{16'h0110, 16'h0108, 16'h0118, 16'h0104};
      wr(bra_pkg::ADDR_CIRC_CTRL, 16'h8303);
      wr(bra_pkg::ADDR_BIT_REV_CTRL, 16'h8008);
      rd(bra_pkg::ADDR_BIT_REV_CTRL, 16'h8008, "pivot");
      p = 16'h0100;
      for (int i = 0; i < 4; i++) begin
         ea(1'h1, 1'h0, 4'h3, bra_pkg::BRA_AM_POST_INC, p);
         `CHK("rev ea", p, data_addr)
         `CHK("rev next", seq[i], pointer_next)
         p = seq[i];
      end
      ea(1'h1, 1'h0, 4'h3, bra_pkg::BRA_AM_PRE_INC, p);
      `CHK("rev pre", 16'h0114, data_addr)
      foreach (neg[i]) begin
         ea(neg[i][8], neg[i][7], neg[i][6:3], neg[i][2:0], p);
         `CHK("no rev", 1'h0, rev_active)
         `CHK("normal ea", p, data_addr)
         `CHK("mod hold", p, pointer_next)
      end
      wr(bra_pkg::ADDR_CIRC_CTRL, 16'h0f0f);
      ea(1'h1, 1'h0, 4'hf, bra_pkg::BRA_AM_POST_INC, p);
      `CHK("sel 15", 1'h0, rev_active)
   endtask
   task automatic t_win();
      logic [2:0] ctx [4] = '{3'h0, 3'h4, 3'h3, 3'h2};
      logic [1:0] cost [4] = '{2'h2, 2'h1, 2'h2, 2'h0};
      // page bit 0 clear while address bit 15 is set: bit 15 must come from the page
      wr(bra_pkg::ADDR_VISIBILITY_PAGE, 16'h0034);
      ea(1'h0, 1'h0, 4'h5, bra_pkg::BRA_AM_INDIRECT, 16'h9234);
      `CHK("win off", 1'h0, prog_req)
      wr(bra_pkg::ADDR_CORE_CTRL, 16'h0004);
      rd(bra_pkg::ADDR_STATUS, 16'h0004, "status");
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         {instr_move, in_repeat, repeat_edge} <= ctx[i];
         ea(1'h0, 1'h0, 4'h5, bra_pkg::BRA_AM_INDIRECT, 16'h9234);
         `CHK("win req", 1'h1, prog_req)
         `CHK("win addr", 24'h1a1234, prog_addr)
         `CHK("win space", 1'h0, prog_config)
         `CHK("win cost", cost[i], extra_cycles)
      end
      ea(1'h0, 1'h0, 4'h5, bra_pkg::BRA_AM_INDIRECT, 16'h1234);
      `CHK("low half", 1'h0, prog_req)
   endtask
   task automatic t_tab();
      logic [18:0] tc [6] = '{{3'h0, 16'h89f7}, {3'h2, 16'h00f7}, {3'h3, 16'h0089},
                              {3'h4, 16'h00db}, {3'h6, 16'h00db}, {3'h7, 16'h0000}};
      foreach (tc[i]) begin
         @(posedge core_clk);
         {table_op, table_high, byte_select} <= {1'h1, tc[i][18], tc[i][16]};
         ea(1'h0, tc[i][17], 4'h6, bra_pkg::BRA_AM_INDIRECT, 16'h4a52);
         `CHK("tab addr", 24'h814a52, prog_addr)
         `CHK("tab space", 1'h1, prog_config)
         @(posedge core_clk);
         #1 `CHK("tab data", tc[i][15:0], table_rdata)
      end
      ea(1'h0, 1'h0, 4'h5, bra_pkg::BRA_AM_INDIRECT, 16'h9234);
      `CHK("tab no win", 24'h819234, prog_addr)
   endtask
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'h0;
      t_pc_regs();
      t_rev();
      t_win();
      t_tab();
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge core_clk);
      fails++;
      report_and_stop();
   end
endmodule
